// [include/rpwt_pkg.sv]
// Package for the remote pulse width timer: addresses, fields, reset values, bus carrier
package rpwt_pkg;
  localparam logic [7:0] RPWT_ADDR_CTRL    = 8'he8;
  localparam logic [7:0] RPWT_ADDR_SHARED  = 8'he9;
  localparam logic [7:0] RPWT_ADDR_FALL    = 8'hea;

  localparam int unsigned RPWT_BIT_ST      = 0;
  localparam int unsigned RPWT_BIT_RUN     = 1;
  localparam int unsigned RPWT_CKSEL_LSB   = 2;
  localparam int unsigned RPWT_BIT_CAP     = 5;

  localparam logic [7:0] RPWT_CTRL_RST     = 8'h00;
  localparam logic [7:0] RPWT_CTRL_MASK    = 8'h3f;
  localparam logic [7:0] RPWT_CAP_RST      = 8'h00;
  localparam logic [7:0] RPWT_CNT_RST      = 8'h00;
  localparam logic [7:0] RPWT_DATA_RST     = 8'h00;

  localparam int unsigned RPWT_PRE_W       = 12;
  localparam logic [RPWT_PRE_W-1:0] RPWT_PRE_RST = 12'h000;

  typedef enum logic [2:0] {
    RPWT_CK_OFF0  = 3'h0,
    RPWT_CK_OFF1  = 3'h1,
    RPWT_CK_D32   = 3'h2,
    RPWT_CK_D256  = 3'h3,
    RPWT_CK_D512  = 3'h4,
    RPWT_CK_D1024 = 3'h5,
    RPWT_CK_D2048 = 3'h6,
    RPWT_CK_D4096 = 3'h7
  } rpwt_cksel_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
    logic [7:0] wdata;
    logic       rd;
  } rpwt_req_s;
endpackage

// [logic/rpwt_remote_timer.sv]
// Remote pulse width timer: free-running counter, filtered edge capture, register port
// Operation
// - Free 8-bit counter captured at valid edges
// - Sample every two count clocks, twice
// - Pulses under two count clocks ignored
// - Capture counter on detected valid edge
// - Rising capture updates only on rise
// - Falling capture updates only on fall
// - Captures readable, zero after reset
// - Counter counts pulses, cleared by stop
// - Control bit 5 selects capture mode
// - Bits 4..2 select oscillator divider
// - Control bit 1 pauses or runs
// - Control bit 0 stops/clears, restarts
// - Shared address: capture mode reads capture
// - Control register: bit and byte writes
// - Control register resets to zero
module rpwt_remote_timer
  import rpwt_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire rpwt_req_s        bus_req,
  output logic [7:0]            bus_rdata,
  input  wire logic             pulse_input_pin,
  output logic [7:0]            write_only_data_reg,
  output logic                  capture_event
);

  // Prescaler tap: count pulse when the low bits of the divider are all ones
  function automatic logic tick_of(input rpwt_cksel_e sel,
                                   input logic [RPWT_PRE_W-1:0] pre);
    logic t;
    t = 1'b0;
    unique case (sel)
      RPWT_CK_OFF0, RPWT_CK_OFF1: t = 1'b0;
      RPWT_CK_D32:   t = &pre[4:0];
      RPWT_CK_D256:  t = &pre[7:0];
      RPWT_CK_D512:  t = &pre[8:0];
      RPWT_CK_D1024: t = &pre[9:0];
      RPWT_CK_D2048: t = &pre[10:0];
      RPWT_CK_D4096: t = &pre[11:0];
    endcase
    return t;
  endfunction

  // Control address hit, shared by the write decode and the restart detect
  function automatic logic ctrl_hit(input logic [7:0] addr);
    return addr == RPWT_ADDR_CTRL;
  endfunction

  logic [7:0]            ctrl_q,  ctrl_d;
  logic [RPWT_PRE_W-1:0] pre_q,   pre_d;
  logic [CNT_W-1:0]      cnt_q,   cnt_d;
  logic [CNT_W-1:0]      rise_q,  rise_d;
  logic [CNT_W-1:0]      fall_q,  fall_d;
  logic                  phase_q, phase_d;
  logic                  samp1_q, samp1_d;
  logic                  level_q, level_d;
  logic [7:0]            data_q,  data_d;
  logic [7:0]            rdata_q, rdata_d;
  logic                  cev_q,   cev_d;

  logic count_tick;
  logic sample_tick;
  logic edge_seen;
  logic cap_mode;
  logic restart;

  assign count_tick  = tick_of(rpwt_cksel_e'(ctrl_q[RPWT_CKSEL_LSB +: 3]), pre_q);
  assign sample_tick = count_tick & phase_q;
  // New level held on two consecutive samples; shorter pulses never qualify
  assign edge_seen   = sample_tick & (samp1_q == pulse_input_pin) & (samp1_q != level_q);
  assign cap_mode    = ctrl_q[RPWT_BIT_CAP];
  // Writing a one to stop/clear restarts from zero even when it was already set
  assign restart     = ctrl_hit(bus_req.addr) &
                       ((bus_req.wr & bus_req.wdata[RPWT_BIT_ST]) |
                        (~bus_req.wr & bus_req.bit_wr & bus_req.bit_val &
                         (bus_req.bit_sel == 3'(RPWT_BIT_ST))));

  // Control register: byte write or single-bit write
  always_comb begin
    ctrl_d = ctrl_q;
    if (bus_req.wr && ctrl_hit(bus_req.addr)) begin
      ctrl_d = bus_req.wdata & RPWT_CTRL_MASK;
    end else if (bus_req.bit_wr && ctrl_hit(bus_req.addr)) begin
      ctrl_d[bus_req.bit_sel] = bus_req.bit_val;
      ctrl_d = ctrl_d & RPWT_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= RPWT_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Write-only data register behind the shared address
  always_comb begin
    data_d = data_q;
    if (bus_req.wr && bus_req.addr == RPWT_ADDR_SHARED) begin
      data_d = bus_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_q <= RPWT_DATA_RST;
    end else begin
      data_q <= data_d;
    end
  end

  // Prescaler runs always; sampling phase toggles on each count pulse of the selected clock
  always_comb begin
    pre_d   = pre_q + 1'b1;
    phase_d = phase_q;
    if (count_tick) begin
      phase_d = ~phase_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q   <= RPWT_PRE_RST;
      phase_q <= 1'b0;
    end else begin
      pre_q   <= pre_d;
      phase_q <= phase_d;
    end
  end

  // Counter: held at zero while stopped, wraps freely while running
  always_comb begin
    cnt_d = cnt_q;
    if (!ctrl_q[RPWT_BIT_ST] || restart) begin
      cnt_d = CNT_W'(RPWT_CNT_RST);
    end else if (ctrl_q[RPWT_BIT_RUN] && count_tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_W'(RPWT_CNT_RST);
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Edge filter: last sample and the level last accepted as valid
  always_comb begin
    samp1_d = samp1_q;
    level_d = level_q;
    if (sample_tick) begin
      samp1_d = pulse_input_pin;
    end
    if (edge_seen) begin
      level_d = samp1_q;
    end
  end

  // Level starts low: the pin is assumed idle low, so no false edge after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      samp1_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      samp1_q <= samp1_d;
      level_q <= level_d;
    end
  end

  // Captures only in capture mode; timer mode still tracks the level
  always_comb begin
    rise_d = rise_q;
    fall_d = fall_q;
    cev_d  = 1'b0;
    if (edge_seen && cap_mode) begin
      cev_d = 1'b1;
      if (samp1_q) begin
        rise_d = cnt_q;
      end else begin
        fall_d = cnt_q;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rise_q <= CNT_W'(RPWT_CAP_RST);
      fall_q <= CNT_W'(RPWT_CAP_RST);
      cev_q  <= 1'b0;
    end else begin
      rise_q <= rise_d;
      fall_q <= fall_d;
      cev_q  <= cev_d;
    end
  end

  // Registered read data, one cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        RPWT_ADDR_CTRL:   rdata_d = ctrl_q;
        RPWT_ADDR_SHARED: rdata_d = 8'(cap_mode ? rise_q : cnt_q);
        RPWT_ADDR_FALL:   rdata_d = 8'(fall_q);
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata           = rdata_q;
  assign write_only_data_reg = data_q;
  assign capture_event       = cev_q;

endmodule

// [tb/rpwt_remote_timer_asserts.sv]
// Port assertions for the remote pulse width timer
module rpwt_remote_timer_asserts
  import rpwt_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire rpwt_req_s  bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic [7:0] write_only_data_reg,
  input wire logic       capture_event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rd = bus_req.rd;
  wire ca = bus_req.addr == 8'he8;
  wire dw = bus_req.wr && bus_req.addr == 8'he9;
  wire nw = !bus_req.wr && !bus_req.bit_wr;
  chk_reset_quiet: assert property ($fell(rst) |-> !capture_event && bus_rdata == 8'h00)
    else $error("outputs busy after reset");
  // Samples lie at least 64 cycles apart
  chk_event_gap: assert property (capture_event |=> !capture_event [*8])
    else $error("capture pulses too close");
  chk_rdata_hold: assert property (!rd |=> $stable(bus_rdata))
    else $error("read data moved");
  chk_unmapped_zero: assert property (rd && !(bus_req.addr inside {[8'he8:8'hea]})
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  chk_ctrl_top: assert property (rd && ca |=> bus_rdata[7:6] == 2'h0)
    else $error("control top bits set");
  chk_ctrl_readback: assert property (bus_req.wr && ca ##1 nw ##1 rd && ca && nw
    |=> bus_rdata == ($past(bus_req.wdata, 3) & 8'h3f)) else $error("control readback");
  chk_data_write: assert property (dw |=> write_only_data_reg == $past(bus_req.wdata))
    else $error("data register not written");
  chk_data_hold: assert property (!dw |=> $stable(write_only_data_reg))
    else $error("data register moved");
  cover property (capture_event);
  cover property (bus_req.bit_wr && ca);
  cover property (dw);
endmodule

// [tb/rpwt_pulse_src.sv]
// Pulse source model driving the measured input
module rpwt_pulse_src (
  input  wire logic ref_clk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  // Trailing low hold keeps the next level valid too
  task automatic pulse(input int n);
    @(posedge ref_clk) #1 pin = 1'b1;
    repeat (n) @(posedge ref_clk);
    #1 pin = 1'b0;
    repeat (320) @(posedge ref_clk);
  endtask
endmodule

// [tb/test_rpwt_remote_timer.sv]
// Register-level testbench for the remote pulse width timer
module test_rpwt_remote_timer import rpwt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  rpwt_req_s  req     = '0;
  logic [7:0] rdata, dreg, rv, r0;
  logic       pin, ev;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         n_ev = 0;
  int         w[2] = '{640, 9600};
  logic [7:0] ew[2] = '{8'd20, 8'd44};
  int         dv[8] = '{0, 0, 32, 256, 512, 1024, 2048, 4096};
  rpwt_remote_timer u_rpwt_remote_timer (.ref_clk(ref_clk), .rst(rst), .bus_req(req),
    .bus_rdata(rdata), .pulse_input_pin(pin), .write_only_data_reg(dreg), .capture_event(ev));
  rpwt_pulse_src u_rpwt_pulse_src (.ref_clk(ref_clk), .pin(pin));
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (ev === 1'b1) n_ev++;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // k is {rd, bit_wr, wr}; a bit write takes select d[2:0], value d[7]
  task automatic bus(input logic [7:0] a, input logic [2:0] k, input logic [7:0] d);
    @(posedge ref_clk) #1 req = '{a, k[0], k[1], d[2:0], d[7], d, k[2]};
    @(posedge ref_clk) #1 req = '0;
    rv = rdata;
  endtask
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(8'he8 + 8'(i), 3'h4, 8'h00);
      chk(rv, 8'h00);
    end
    bus(8'he8, 3'h1, 8'hff);
    bus(8'he8, 3'h4, 8'h00);
    chk(rv, 8'h3f);
    bus(8'he8, 3'h1, 8'h0b);
    u_rpwt_pulse_src.pulse(320);
    bus(8'he9, 3'h4, 8'h00);
    chk(8'(rv inside {8'd20, 8'd21}), 8'h01);
    chk(8'(n_ev), 8'h00);
    bus(8'he8, 3'h2, 8'h01);
    bus(8'he9, 3'h4, 8'h00);
    r0 = rv;
    repeat (100) @(posedge ref_clk);
    bus(8'he9, 3'h4, 8'h00);
    chk(rv, r0);
    bus(8'he8, 3'h2, 8'h00);
    bus(8'he9, 3'h4, 8'h00);
    chk(rv, 8'h00);
    // Each divided select over two of its periods: exactly two counts; off selects none; restart clears
    foreach (dv[c]) begin
      bus(8'he8, 3'h1, {3'h0, 3'(c), 2'h3});
      repeat (dv[c] > 0 ? 2 * dv[c] - 1 : 127) @(posedge ref_clk);
      bus(8'he9, 3'h4, 8'h00);
      chk(rv, dv[c] > 0 ? 8'h02 : 8'h00);
    end
    bus(8'he8, 3'h1, 8'h2b);
    bus(8'he9, 3'h1, 8'h5a);
    chk(dreg, 8'h5a);
    foreach (w[i]) begin
      u_rpwt_pulse_src.pulse(w[i]);
      bus(8'he9, 3'h4, 8'h00);
      r0 = rv;
      bus(8'hea, 3'h4, 8'h00);
      chk(rv - r0, ew[i]);
    end
    chk(8'(n_ev), 8'h04);
    r0 = rv;
    u_rpwt_pulse_src.pulse(60);
    bus(8'hea, 3'h4, 8'h00);
    chk(rv, r0);
    chk(8'(n_ev), 8'h04);
    close_out();
  end
  // Run needs about 29000 cycles; allow twice that
  initial begin
    #3000000;
    n_mismatch++;
    close_out();
  end
endmodule
bind rpwt_remote_timer rpwt_remote_timer_asserts u_rpwt_remote_timer_asserts (
  .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .write_only_data_reg(write_only_data_reg), .capture_event(capture_event));
